//--- hdl/card_port_pkg.sv
package card_port_pkg;
	// control byte layout
	localparam int CTRL_SESSION = 0;
	localparam int CTRL_WARM = 1;
	localparam int CTRL_SUPPLY_3V = 2;
	localparam int CTRL_CLK_STOP = 3;
	localparam int CTRL_STOP_LEVEL = 4;
	localparam int CTRL_DIV_LO = 5;
	localparam int CTRL_DIV_HI = 6;
	localparam int CTRL_LINE_EN = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// bus address: fixed upper bits, pick pins on bits 3..1
	localparam logic [2:0] ADDR_TOP = 3'h4;
	localparam logic [1:0] DIV_BY8 = 2'h0;
	localparam logic [1:0] DIV_BY4 = 2'h1;
	localparam logic [1:0] DIV_BY2 = 2'h2;
	localparam int DIV_CNT_W = 4;
	// bus timing
	localparam int CLK_NS = 20;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;
	localparam int QTR_W = 6;
	// controller register map (byte addresses)
	localparam logic [31:0] OFS_CMD = 32'h0000_0000;
	localparam logic [31:0] OFS_STAT = 32'h0000_0004;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_RW = 15;
	localparam int CMD_GO = 16;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_RD_LSB = 8;
endpackage

//--- hdl/card_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface card_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// open-drain wire: pulled high unless an enabled driver pulls low
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport host(output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
	modport device(output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface
`default_nettype wire

//--- hdl/card_port_device.sv
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: slave on two-wire bus, writes and reads
// R2: address 0x40..0x4E from three pick pins
// R3: address plus direction, zero means write
// R4: acknowledge low on matching address
// R5: eight data bits stored, acknowledged low
// R6: master ends write with stop
// R7: control register zero after reset
// R8: bit 0 starts activation or deactivation
// R9: bit 1 warm reset, hardware clears
// R10: bit 2 picks 3 V or 5 V
// R11: host keeps bit 2 while deactivating 3 V
// R12: bit 3 holds card clock stopped
// R13: bit 4 sets stopped clock level
// R14: bits 6..5 pick card clock divider
// R15: bit 7 passes card line to host
// R16: read sends status, master nacks, stop
// R17: mismatched address left unacknowledged, ignored
// R18: control byte applies after all bits

// =====================================================
// input filter: three-flop chain plus output flop, change taken when last two agree
module pin_filter #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			q_o <= INIT;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q_o <= (s2 & s3) | (q_o & (s2 | s3));
		end
	end
endmodule

// =====================================================
module card_port_device (
	input wire logic clk_i,
	input wire logic rst_i,
	card_link_if.device link,
	input wire logic addr_pick_bit0_i,
	input wire logic addr_pick_bit1_i,
	input wire logic addr_pick_bit2_i,
	input wire logic [7:0] status_i,
	input wire logic card_answer_i,
	input wire logic card_mute_i,
	input wire logic card_line_i,
	output logic session_o,
	output logic warm_reset_o,
	output logic supply_3v_o,
	output logic card_clk_o,
	output logic host_side_card_line_o,
	output logic host_side_card_line_oe_o
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_IGNORE
	} dev_state_type;

	dev_state_type state;
	logic [7:0] card_control;
	logic [7:0] shreg;
	logic [3:0] bit_cnt;
	logic is_read;
	logic drive_low;
	logic sda_out;
	logic scl_f;
	logic sda_f;
	logic scl_d;
	logic sda_d;
	logic [2:0] pick_f;
	logic line_f;
	logic [card_port_pkg::DIV_CNT_W-1:0] div_cnt;

	pin_filter #(.W(1), .INIT(1'b1)) u_scl (
		.clk_i(clk_i), .rst_i(rst_i), .d_i(link.scl), .q_o(scl_f));
	pin_filter #(.W(1), .INIT(1'b1)) u_sda (
		.clk_i(clk_i), .rst_i(rst_i), .d_i(link.sda), .q_o(sda_f));
	pin_filter #(.W(3), .INIT(3'h0)) u_pick (
		.clk_i(clk_i), .rst_i(rst_i),
		.d_i({addr_pick_bit2_i, addr_pick_bit1_i, addr_pick_bit0_i}), .q_o(pick_f));
	pin_filter #(.W(1), .INIT(1'b1)) u_line (
		.clk_i(clk_i), .rst_i(rst_i), .d_i(card_line_i), .q_o(line_f));

	// =====================================================
	// bus events
	wire scl_rise = scl_f && !scl_d;
	wire scl_fall = !scl_f && scl_d;
	wire start_seen = scl_f && scl_d && sda_d && !sda_f;
	wire stop_seen = scl_f && scl_d && !sda_d && sda_f;
	wire [6:0] my_addr = {1'b0, card_port_pkg::ADDR_TOP, pick_f}; // [R2]
	wire addr_match = shreg[7:1] == my_addr;
	wire byte_done = bit_cnt == 4'h8;
	wire [7:0] next_shreg = {shreg[6:0], sda_f};
	// hardware clear of warm reset, but a write in the same cycle wins
	wire warm_clear = card_answer_i || card_mute_i;
	wire ctrl_load = state == ST_WR && scl_fall && byte_done;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	// =====================================================
	// bus slave
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			shreg <= 8'h00;
			bit_cnt <= 4'h0;
			is_read <= 1'b0;
			drive_low <= 1'b0;
		end else if (start_seen) begin // [R3]
			state <= ST_ADDR;
			bit_cnt <= 4'h0;
			drive_low <= 1'b0;
		end else if (stop_seen) begin // [R6]
			state <= ST_IDLE;
			drive_low <= 1'b0;
		end else begin
			case (state)
				ST_ADDR: begin
					if (scl_rise) begin
						shreg <= next_shreg;
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						is_read <= shreg[0]; // [R3]
						if (addr_match) begin
							drive_low <= 1'b1; // [R4]
							state <= ST_ADDR_ACK;
						end else begin
							state <= ST_IGNORE; // [R17]
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (is_read) begin
							shreg <= {status_i[6:0], 1'b0}; // [R16]
							drive_low <= !status_i[7];
							bit_cnt <= 4'h1;
							state <= ST_RD;
						end else begin
							drive_low <= 1'b0;
							bit_cnt <= 4'h0;
							state <= ST_WR;
						end
					end
				end
				ST_WR: begin
					if (scl_rise) begin
						shreg <= next_shreg; // [R5]
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						drive_low <= 1'b1; // [R5]
						state <= ST_WR_ACK;
					end
				end
				ST_WR_ACK: begin
					if (scl_fall) begin
						drive_low <= 1'b0;
						state <= ST_IGNORE;
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (byte_done) begin
							drive_low <= 1'b0; // [R16]
							state <= ST_RD_ACK;
						end else begin
							drive_low <= !shreg[7];
							shreg <= {shreg[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				ST_RD_ACK: begin
					// single status byte; master nack or not, wait for stop
					if (scl_rise) begin
						state <= ST_IGNORE; // [R16]
					end
				end
				default: begin
					drive_low <= 1'b0;
				end
			endcase
		end
	end

	// =====================================================
	// control register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			card_control <= card_port_pkg::CTRL_RESET; // [R7]
		end else if (ctrl_load) begin
			card_control <= shreg; // [R18] [R8] [R10]
		end else if (warm_clear) begin
			card_control[card_port_pkg::CTRL_WARM] <= 1'b0; // [R9]
		end
	end

	// =====================================================
	// card clock; the fastest flop-made clock is half of clk_i,
	// so clk_i/2 stands for the undivided input clock
	wire [1:0] div_sel = {card_control[card_port_pkg::CTRL_DIV_HI],
		card_control[card_port_pkg::CTRL_DIV_LO]};
	wire [card_port_pkg::DIV_CNT_W-1:0] next_div_cnt = div_cnt + 1'b1;
	wire div_tap = (div_sel == card_port_pkg::DIV_BY8) ? next_div_cnt[3] :
		(div_sel == card_port_pkg::DIV_BY4) ? next_div_cnt[2] :
		(div_sel == card_port_pkg::DIV_BY2) ? next_div_cnt[1] : next_div_cnt[0]; // [R14]
	wire clk_stop = card_control[card_port_pkg::CTRL_CLK_STOP];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt <= '0;
			card_clk_o <= 1'b0;
			sda_out <= 1'b0;
			host_side_card_line_o <= 1'b1;
			host_side_card_line_oe_o <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			sda_out <= 1'b0;
			if (clk_stop) begin
				card_clk_o <= card_control[card_port_pkg::CTRL_STOP_LEVEL]; // [R12] [R13]
			end else begin
				card_clk_o <= div_tap;
			end
			host_side_card_line_o <= line_f; // [R15]
			host_side_card_line_oe_o <= card_control[card_port_pkg::CTRL_LINE_EN]; // [R15]
		end
	end

	assign session_o = card_control[card_port_pkg::CTRL_SESSION]; // [R8]
	assign warm_reset_o = card_control[card_port_pkg::CTRL_WARM]; // [R9]
	assign supply_3v_o = card_control[card_port_pkg::CTRL_SUPPLY_3V]; // [R10]
	assign link.dev_sda_o = sda_out;
	assign link.dev_sda_oe = drive_low; // [R1]
endmodule
`default_nettype wire

//--- hdl/card_port_host.sv
`timescale 1ns/1ps
`default_nettype none
module card_port_host (
	input wire logic clk_i,
	input wire logic rst_i,
	card_link_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} host_state_type;

	host_state_type state;
	logic [card_port_pkg::QTR_W-1:0] qcnt;
	logic [1:0] phase;
	logic byte1;
	logic [3:0] bit_n;
	logic [6:0] tgt_addr;
	logic rw;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic nack;
	logic scl_oe;
	logic sda_oe;
	logic sda_f;

	pin_filter #(.W(1), .INIT(1'b1)) u_sda (
		.clk_i(clk_i), .rst_i(rst_i), .d_i(link.sda), .q_o(sda_f));

	// =====================================================
	// register slave, answers one cycle into the access phase
	wire access = psel && penable && !pready;
	wire hit_cmd = paddr == card_port_pkg::OFS_CMD;
	wire hit_stat = paddr == card_port_pkg::OFS_STAT;
	wire busy = state != H_IDLE;
	// a command starts only at the edge that completes the bus transfer
	wire go = psel && penable && pready && pwrite && hit_cmd &&
		pwdata[card_port_pkg::CMD_GO] && !busy;
	wire [31:0] stat_word = {16'h0000, rdata, 6'h00, nack, busy};
	wire [31:0] cmd_word = {16'h0000, rw, tgt_addr, wdata};

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access;
			pslverr <= access && !hit_cmd && !hit_stat;
			if (access && !pwrite) begin
				prdata <= hit_stat ? stat_word : (hit_cmd ? cmd_word : 32'h0000_0000);
			end
		end
	end

	// =====================================================
	// bus master, each bit is four quarter periods
	wire tick = qcnt == 6'(card_port_pkg::QTR_CYC - 1);
	wire [7:0] tx_byte = byte1 ? wdata : {tgt_addr, rw};
	wire tx_bit = tx_byte[3'(7 - bit_n)];
	wire is_ack = bit_n == 4'h8;
	wire drive_data = !is_ack && (!byte1 || !rw);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= H_IDLE;
			qcnt <= '0;
			phase <= 2'h0;
			byte1 <= 1'b0;
			bit_n <= 4'h0;
			tgt_addr <= 7'h00;
			rw <= 1'b0;
			wdata <= 8'h00;
			rdata <= 8'h00;
			nack <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (state == H_IDLE) begin
			qcnt <= '0;
			phase <= 2'h0;
			if (go) begin
				wdata <= pwdata[7:0];
				tgt_addr <= pwdata[card_port_pkg::CMD_ADDR_LSB +: 7];
				rw <= pwdata[card_port_pkg::CMD_RW];
				nack <= 1'b0;
				state <= H_START;
			end
		end else begin
			qcnt <= tick ? '0 : qcnt + 1'b1;
			if (tick) begin
				phase <= phase + 2'h1;
				case (state)
					H_START: begin
						// start: data falls while clock is high
						if (phase == 2'h1) sda_oe <= 1'b1;
						if (phase == 2'h2) scl_oe <= 1'b1;
						if (phase == 2'h3) begin
							byte1 <= 1'b0;
							bit_n <= 4'h0;
							state <= H_BITS;
						end
					end
					H_BITS: begin
						case (phase)
							2'h0: sda_oe <= drive_data && !tx_bit;
							2'h1: scl_oe <= 1'b0;
							2'h2: begin
								if (is_ack && !byte1) nack <= sda_f;
								if (!is_ack && byte1 && rw) rdata <= {rdata[6:0], sda_f};
							end
							default: begin
								scl_oe <= 1'b1;
								if (!is_ack) begin
									bit_n <= bit_n + 4'h1;
								end else if (!byte1 && !nack) begin
									byte1 <= 1'b1;
									bit_n <= 4'h0;
								end else begin
									state <= H_STOP;
								end
							end
						endcase
					end
					default: begin
						// stop: data rises while clock is high
						if (phase == 2'h0) sda_oe <= 1'b1;
						if (phase == 2'h1) scl_oe <= 1'b0;
						if (phase == 2'h2) sda_oe <= 1'b0; // [R6]
						if (phase == 2'h3) state <= H_IDLE;
					end
				endcase
			end
		end
	end

	assign link.host_scl_o = 1'b0;
	assign link.host_scl_oe = scl_oe;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = sda_oe;
endmodule
`default_nettype wire

//--- tb/card_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module card_link_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==============================================
	// clock phases
	property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
	a_scl_high: assert property (p_scl_high) else $error("scl high too short");
	property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl low too short");
	// no stretching, so a low phase that never ends means a stuck master
	property p_scl_low_max; $fell(scl) |-> ##[1:200] scl; endproperty
	a_scl_low_max: assert property (p_scl_low_max) else $error("scl stuck low");
	// ==============================================
	// device data line
	property p_ack_rise; $rose(dev_sda_oe) |-> !scl; endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("device pulled sda in scl high");
	property p_ack_fall; $fell(dev_sda_oe) |-> !scl; endproperty
	a_ack_fall: assert property (p_ack_fall) else $error("device freed sda in scl high");
	property p_dev_hold; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
	a_dev_hold: assert property (p_dev_hold) else $error("device sda moved in scl high");
	property p_no_fight; scl |-> !(dev_sda_oe && host_sda_oe); endproperty
	a_no_fight: assert property (p_no_fight) else $error("both ends pull sda");
	// ==============================================
	// framing
	property p_start; scl && $past(scl) && $fell(sda) |-> host_sda_oe; endproperty
	a_start: assert property (p_start) else $error("start not made by host");
	property p_stop; scl && $past(scl) && $rose(sda) |=> scl [*8]; endproperty
	a_stop: assert property (p_stop) else $error("bus not idle after stop");
	c_ack: cover property ($rose(dev_sda_oe));
	c_start: cover property (scl && $past(scl) && $fell(sda));
	c_stop: cover property (scl && $past(scl) && $rose(sda));
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] pick = 3'h0;
	logic [7:0] status_i = 8'h5A;
	logic card_answer_i = 1'b0;
	logic card_mute_i = 1'b0;
	logic card_line_i = 1'b0;
	logic session_o, warm_reset_o, supply_3v_o, card_clk_o, line_o, line_oe;
	logic [31:0] q;
	logic [31:0] n;
	logic err;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	card_link_if link();
	card_port_host i_card_port_host(.clk_i(clk_i), .rst_i(rst_i), .link(link), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	card_port_device i_card_port_device(.clk_i(clk_i), .rst_i(rst_i), .link(link),
		.addr_pick_bit0_i(pick[0]), .addr_pick_bit1_i(pick[1]), .addr_pick_bit2_i(pick[2]),
		.status_i(status_i), .card_answer_i(card_answer_i), .card_mute_i(card_mute_i),
		.card_line_i(card_line_i), .session_o(session_o), .warm_reset_o(warm_reset_o),
		.supply_3v_o(supply_3v_o), .card_clk_o(card_clk_o), .host_side_card_line_o(line_o),
		.host_side_card_line_oe_o(line_oe));
	card_link_asserts i_card_link_asserts(.clk_i(clk_i), .rst_i(rst_i), .scl(link.scl),
		.sda(link.sda), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe));
	always #10 clk_i = ~clk_i;
	// ==============================================
	// tasks
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one link transfer, then poll until the controller is idle
	task xfer(input logic rw, input logic [6:0] a, input logic [7:0] d);
		apb(1'b1, card_port_pkg::OFS_CMD, {15'h0, 1'b1, rw, a, d});
		q = 32'h1;
		while (q[card_port_pkg::STAT_BUSY] !== 1'b0) apb(1'b0, card_port_pkg::OFS_STAT, 32'h0);
	endtask
	// the 128-cycle sample window holds exactly one edge per half period
	task count_clk;
		logic prev;
		n = 32'h0;
		@(posedge clk_i);
		prev = card_clk_o;
		repeat (128) begin
			@(posedge clk_i);
			if (card_clk_o !== prev) n = n + 32'h1;
			prev = card_clk_o;
		end
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			errors++;
			print_verdict;
		end
	end
	// ==============================================
	// scenarios
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("ctrl_rst", {28'h0, line_oe, supply_3v_o, warm_reset_o, session_o}, 32'h0);
		apb(1'b0, 32'h0000_0010, 32'h0);
		check("unmapped", {31'h0, err}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			pick <= i[2:0];
			card_line_i <= i[0];
			xfer(1'b0, {4'h4, i[2:0]}, {1'b1, i[1:0], 5'h05});
			check("nack", {31'h0, q[card_port_pkg::STAT_NACK]}, 32'h0);
			check("ctrl", {29'h0, line_oe, supply_3v_o, session_o}, 32'h7);
			check("line", {31'h0, line_o}, {31'h0, i[0]});
			count_clk;
			check("clk_div", n, 32'h10 << i[1:0]);
		end
		xfer(1'b0, 7'h26, 8'h00);
		check("nack_miss", {31'h0, q[card_port_pkg::STAT_NACK]}, 32'h1);
		check("keep", {31'h0, session_o}, 32'h1);
		xfer(1'b1, 7'h27, 8'h00);
		check("rd", {24'h0, q[15:8]}, 32'h5A);
		for (int j = 0; j < 2; j++) begin
			xfer(1'b0, 7'h27, 8'h87);
			check("warm_set", {31'h0, warm_reset_o}, 32'h1);
			card_answer_i <= (j == 0);
			card_mute_i <= (j == 1);
			@(posedge clk_i);
			card_answer_i <= 1'b0;
			card_mute_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			check("warm_clr", {31'h0, warm_reset_o}, 32'h0);
		end
		for (int k = 0; k < 2; k++) begin
			xfer(1'b0, 7'h27, k[0] ? 8'h8D : 8'h9D);
			count_clk;
			check("stop_cnt", n, 32'h0);
			check("stop_lvl", {31'h0, card_clk_o}, {31'h0, !k[0]});
		end
		// the supply bit stays set while the 3 V session closes
		xfer(1'b0, 7'h27, 8'h04);
		check("deact", {29'h0, line_oe, supply_3v_o, session_o}, 32'h2);
		print_verdict;
	end
endmodule
`default_nettype wire
